// ---- hdl/complement_and_bcd_adjust_ops.sv ----
/*
   Complement-to-accumulator and decimal adjust datapath of an 8-bit core ALU.
   Assumes operands and flags come from logic on the same clock, and that the
   core writes back the results on the cycle after the request.
*/
`timescale 1ns/1ps
module complement_and_bcd_adjust_ops (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Request
   input wire logic opValid,
   input wire alu_ops_pkg::op_e opSel,
   input wire logic [alu_ops_pkg::DATA_W-1:0] accIn,
   input wire logic [alu_ops_pkg::DATA_W-1:0] memIn,
   input wire logic halfCarryIn,
   input wire logic carryIn,
   // Accumulator write-back
   output logic accWrite,
   output logic [alu_ops_pkg::DATA_W-1:0] accData,
   // Data memory write-back
   output logic memWrite,
   output logic [alu_ops_pkg::DATA_W-1:0] memData,
   // Flag write-back
   output logic zeroWrite,
   output logic zeroFlag,
   output logic carryWrite,
   output logic carryFlag
);
   import alu_ops_pkg::*;

   // Decode
   wire logic doComplement;
   wire logic doAdjust;
   assign doComplement = opValid && (opSel == OP_COMPLEMENT_TO_ACC);
   assign doAdjust = opValid && (opSel == OP_DECIMAL_ADJUST);

   // Complement path
   wire logic [DATA_W-1:0] complemented;
   assign complemented = ~memIn;

   // Nibble checks
   wire logic lowOver;
   wire logic highOver;
   wire logic lowAdjust;
   wire logic highAdjust;
   assign lowOver = accIn[3:0] > NIBBLE_MAX;
   assign highOver = accIn[7:4] > NIBBLE_MAX;
   assign lowAdjust = lowOver || halfCarryIn;
   assign highAdjust = highOver || carryIn;

   // Correction select
   wire logic [DATA_W-1:0] correction;
   assign correction = highAdjust ? (lowAdjust ? CORR_BOTH : CORR_HIGH)
                                  : (lowAdjust ? CORR_LOW : CORR_NONE);

   // Corrected sum with carry out
   wire logic [DATA_W:0] adjustSum;
   assign adjustSum = {1'b0, accIn} + {1'b0, correction};

   // Carry result of decimal adjust, never cleared
   wire logic adjustCarry;
   assign adjustCarry = carryIn || highAdjust || adjustSum[DATA_W];

   // Next values
   wire logic next_accWrite;
   wire logic [DATA_W-1:0] next_accData;
   wire logic next_memWrite;
   wire logic [DATA_W-1:0] next_memData;
   assign next_accWrite = doComplement;
   assign next_accData = doComplement ? complemented : accData;
   assign next_memWrite = doAdjust;
   assign next_memData = doAdjust ? adjustSum[DATA_W-1:0] : memData;

   wire logic next_zeroWrite;
   wire logic next_zeroFlag;
   wire logic next_carryWrite;
   wire logic next_carryFlag;
   assign next_zeroWrite = doComplement;
   assign next_zeroFlag = doComplement ? (complemented == DATA_RST) : zeroFlag;
   assign next_carryWrite = doAdjust;
   assign next_carryFlag = doAdjust ? adjustCarry : carryFlag;

   // Accumulator write-back register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         accWrite <= FLAG_RST;
         accData <= DATA_RST;
      end else begin
         accWrite <= next_accWrite;
         accData <= next_accData;
      end
   end

   // Memory write-back register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         memWrite <= FLAG_RST;
         memData <= DATA_RST;
      end else begin
         memWrite <= next_memWrite;
         memData <= next_memData;
      end
   end

   // Zero flag register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         zeroWrite <= FLAG_RST;
         zeroFlag <= FLAG_RST;
      end else begin
         zeroWrite <= next_zeroWrite;
         zeroFlag <= next_zeroFlag;
      end
   end

   // Carry flag register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         carryWrite <= FLAG_RST;
         carryFlag <= FLAG_RST;
      end else begin
         carryWrite <= next_carryWrite;
         carryFlag <= next_carryFlag;
      end
   end

   // Checks
   a_cpl_acc_result: assert property (@(posedge clk) disable iff (!nrst)
      doComplement |=> accWrite && !memWrite && (accData == ~$past(memIn)))
      else $error("complement result or write strobe wrong");

   a_low_nibble_add: assert property (@(posedge clk) disable iff (!nrst)
      (doAdjust && ((accIn[3:0] > 4'h9) || halfCarryIn))
      |=> memData[3:0] == 4'($past(accIn[3:0]) + 4'h6))
      else $error("low nibble not corrected by six");

   a_low_nibble_keep: assert property (@(posedge clk) disable iff (!nrst)
      (doAdjust && (accIn[3:0] <= 4'h9) && !halfCarryIn)
      |=> memData[3:0] == $past(accIn[3:0]))
      else $error("low nibble changed without cause");

   a_high_only_add: assert property (@(posedge clk) disable iff (!nrst)
      (doAdjust && ((accIn[7:4] > 4'h9) || carryIn) && (accIn[3:0] <= 4'h9) && !halfCarryIn)
      |=> memData == 8'($past(accIn) + 8'h60))
      else $error("high nibble not corrected by six");

   a_corr_set: assert property (@(posedge clk) disable iff (!nrst)
      doAdjust |=> (8'(memData - $past(accIn)) == 8'h00) || (8'(memData - $past(accIn)) == 8'h06)
                || (8'(memData - $past(accIn)) == 8'h60) || (8'(memData - $past(accIn)) == 8'h66))
      else $error("decimal correction outside allowed set");

   a_adj_mem_only: assert property (@(posedge clk) disable iff (!nrst)
      doAdjust |=> memWrite && !accWrite ##1 (!memWrite || $past(doAdjust)))
      else $error("decimal adjust write-back target wrong");

   a_adj_carry: assert property (@(posedge clk) disable iff (!nrst)
      (doAdjust && ((accIn[7:4] > 4'h9) || carryIn)) |=> carryWrite && carryFlag && !zeroWrite)
      else $error("decimal adjust carry not set or extra flag written");

   a_cpl_zero: assert property (@(posedge clk) disable iff (!nrst)
      doComplement |=> zeroWrite && !carryWrite && (zeroFlag == ($past(memIn) == 8'hFF)))
      else $error("complement zero flag wrong");

   a_cpl_zero_set: assert property (@(posedge clk) disable iff (!nrst)
      (doComplement && (memIn == 8'hFF))
      |=> zeroWrite && zeroFlag)
      else $error("complement of all ones did not set zero");

   a_cpl_mem_hold: assert property (@(posedge clk) disable iff (!nrst)
      doComplement
      |=> !memWrite && $stable(memData))
      else $error("complement disturbed the memory result");

   a_cpl_carry_hold: assert property (@(posedge clk) disable iff (!nrst)
      doComplement
      |=> !carryWrite && $stable(carryFlag))
      else $error("complement disturbed the carry flag");

   a_adj_acc_hold: assert property (@(posedge clk) disable iff (!nrst)
      doAdjust
      |=> !accWrite && $stable(accData))
      else $error("decimal adjust disturbed the accumulator result");

   a_adj_zero_hold: assert property (@(posedge clk) disable iff (!nrst)
      doAdjust
      |=> !zeroWrite && $stable(zeroFlag))
      else $error("decimal adjust disturbed the zero flag");

   a_low_only_add: assert property (@(posedge clk) disable iff (!nrst)
      (doAdjust && ((accIn[3:0] > NIBBLE_MAX) || halfCarryIn) && (accIn[7:4] <= NIBBLE_MAX) && !carryIn)
      |=> memData == 8'($past(accIn) + CORR_LOW))
      else $error("low-only correction wrong");

   a_both_add: assert property (@(posedge clk) disable iff (!nrst)
      (doAdjust && ((accIn[3:0] > NIBBLE_MAX) || halfCarryIn) && ((accIn[7:4] > NIBBLE_MAX) || carryIn))
      |=> memData == 8'($past(accIn) + CORR_BOTH))
      else $error("double correction wrong");

   a_zero_corr: assert property (@(posedge clk) disable iff (!nrst)
      (doAdjust && (accIn[3:0] <= NIBBLE_MAX) && !halfCarryIn && (accIn[7:4] <= NIBBLE_MAX) && !carryIn)
      |=> memData == $past(accIn))
      else $error("valid decimal value was altered");

   a_adj_no_carry: assert property (@(posedge clk) disable iff (!nrst)
      (doAdjust && (accIn[7:4] <= NIBBLE_MAX) && !carryIn)
      |=> carryWrite && !carryFlag)
      else $error("carry set although decimal sum below hundred");

   a_idle_strobes: assert property (@(posedge clk) disable iff (!nrst)
      !opValid
      |=> !accWrite && !memWrite && !zeroWrite && !carryWrite)
      else $error("write strobe without a request");

   a_idle_hold: assert property (@(posedge clk) disable iff (!nrst)
      !opValid
      |=> $stable(accData) && $stable(memData) && $stable(zeroFlag) && $stable(carryFlag))
      else $error("result changed without a request");

endmodule

// ---- shared/alu_ops_pkg.sv ----
/*
   Constants and operation codes for the complement and decimal adjust datapath.
   Assumes the instruction decoder presents one operation code per issued instruction.
*/
package alu_ops_pkg;

   // Operations handled by the datapath
   typedef enum logic {
      OP_COMPLEMENT_TO_ACC,
      OP_DECIMAL_ADJUST
   } op_e;

   // Data width
   localparam int DATA_W = 8;

   // Largest valid decimal digit in a nibble
   localparam logic [3:0] NIBBLE_MAX = 4'h9;

   // Decimal adjust corrections
   localparam logic [7:0] CORR_NONE = 8'h00;
   localparam logic [7:0] CORR_LOW = 8'h06;
   localparam logic [7:0] CORR_HIGH = 8'h60;
   localparam logic [7:0] CORR_BOTH = 8'h66;

   // Output reset values
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic FLAG_RST = 1'b0;

   // Result latency in clock cycles
   localparam int RESULT_LATENCY = 1;

endpackage

// ---- bench/test_complement_and_bcd_adjust_ops.sv ----
/*
   Self-checking bench for the complement and decimal adjust datapath.
   Assumes the package is compiled first; the bench drives every port itself.
*/
`timescale 1ns/1ps
module test_complement_and_bcd_adjust_ops;
   import alu_ops_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, opValid = 1'b0, halfCarryIn = 1'b0, carryIn = 1'b0;
   op_e opSel = OP_COMPLEMENT_TO_ACC;
   logic [7:0] accIn = 8'h00, memIn = 8'h00, accData, memData, m, a, corr, lastAcc;
   logic accWrite, memWrite, zeroWrite, zeroFlag, carryWrite, carryFlag, lo, hi;
   logic [8:0] sum;
   logic [9:0] vec [9] = '{10'h048, 10'h028, 10'h04E, 10'h288, 10'h085, 10'h268, 10'h26C, 10'h3FC, 10'h267};
   int nErrors = 0, checked = 0;
   complement_and_bcd_adjust_ops dut (.clk(clk), .nrst(nrst), .opValid(opValid), .opSel(opSel),
      .accIn(accIn), .memIn(memIn), .halfCarryIn(halfCarryIn), .carryIn(carryIn),
      .accWrite(accWrite), .accData(accData), .memWrite(memWrite), .memData(memData),
      .zeroWrite(zeroWrite), .zeroFlag(zeroFlag), .carryWrite(carryWrite), .carryFlag(carryFlag));
   initial forever #10 clk = ~clk;
   task check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         nErrors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task final_report;
      $display("comparisons %0d mismatches %0d", checked, nErrors);
      if (nErrors == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task issue(input op_e op, input logic [7:0] acc, input logic [7:0] mem, input logic hc, input logic c);
      opValid = 1'b1;
      opSel = op;
      accIn = acc;
      memIn = mem;
      halfCarryIn = hc;
      carryIn = c;
      @(posedge clk) #1;
   endtask
   // Back-to-back complements, zero and non-zero results
   task test_complement;
      for (int i = 0; i < 4; i++) begin
         m = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : (i == 2) ? 8'hA5 : 8'h5A;
         issue(OP_COMPLEMENT_TO_ACC, 8'h33, m, 1'b1, 1'b1);
         check(accWrite, 8'h01);
         check(accData, ~m);
         check(memWrite, 8'h00);
         check({zeroWrite, zeroFlag}, {1'b1, m == 8'hFF});
         check(carryWrite, 8'h00);
      end
      lastAcc = ~m;
      $display("complement test done");
   endtask
   // Back-to-back adjusts over every correction constant
   task test_adjust;
      foreach (vec[i]) begin
         {a, lo, hi} = vec[i];
         issue(OP_DECIMAL_ADJUST, a, 8'h00, lo, hi);
         lo = (a[3:0] > 4'h9) | halfCarryIn;
         hi = (a[7:4] > 4'h9) | carryIn;
         corr = {1'b0, hi, hi, 1'b0, 1'b0, lo, lo, 1'b0};
         sum = {1'b0, a} + {1'b0, corr};
         check(memWrite, 8'h01);
         check(memData, sum[7:0]);
         check(accWrite, 8'h00);
         check(accData, lastAcc);
         check({zeroWrite, carryWrite}, 8'h01);
         check(carryFlag, hi);
      end
      $display("decimal adjust test done");
   endtask
   // Idle cycle then asynchronous reset mid-run
   task test_idle_reset;
      opValid = 1'b0;
      @(posedge clk) #1;
      check({accWrite, memWrite, zeroWrite, carryWrite}, 8'h00);
      check(accData, lastAcc);
      check(memData, sum[7:0]);
      nrst = 1'b0;
      #2;
      check(accData, 8'h00);
      check(memData, 8'h00);
      check({zeroFlag, carryFlag}, 8'h00);
      @(posedge clk) #1;
      nrst = 1'b1;
      $display("idle and reset test done");
   endtask
   initial begin
      repeat (4) @(posedge clk);
      #1 nrst = 1'b1;
      test_complement();
      test_adjust();
      test_idle_reset();
      test_complement();
      final_report();
   end
   initial begin
      #5000;
      nErrors++;
      final_report();
   end
endmodule
